// File: common/apfc_regs.svh
// Purpose: Register map and field layout of the ADC post-filter configuration block
// Assumes: 32-bit AXI4-Lite words, byte addresses
// Notes:   Definitions only
`ifndef APFC_REGS_SVH
`define APFC_REGS_SVH

`define APFC_ADDR_W          16
`define APFC_CFG_ADDR        16'h2044
`define APFC_STAT_ADDR       16'h2048
`define APFC_CFG_RESET       32'h00000301
`define APFC_CFG_WMASK       32'h0007FFDF

`define APFC_DFT_GATE_BIT    18
`define APFC_WAVE_GATE_BIT   17
`define APFC_MAINS_GATE_BIT  16
`define APFC_AVG_CNT_HI      15
`define APFC_AVG_CNT_LO      14
`define APFC_S3_DEC_HI       13
`define APFC_S3_DEC_LO       12
`define APFC_S2_DEC_HI       11
`define APFC_S2_DEC_LO       8
`define APFC_AVG_EN_BIT      7
`define APFC_S3_BYP_BIT      6
`define APFC_LOW_HI          4
`define APFC_LOW_LO          0

`define APFC_STAT_AVG_LO     0
`define APFC_STAT_S3_LO      5
`define APFC_STAT_S2_LO      8
`define APFC_STAT_SRC_BIT    19

`define APFC_RESP_OKAY       2'h0
`define APFC_RESP_SLVERR     2'h2

`endif

// File: common/apfc_pkg.sv
// Purpose: Shared types of the ADC post-filter configuration block
// Assumes: Constants live in apfc_regs.svh
// Notes:   Types only
package apfc_pkg;
    typedef logic [31:0] apfc_word_t;
    typedef logic [3:0]  apfc_strb_t;
    typedef logic [1:0]  apfc_resp_t;
    typedef logic [4:0]  apfc_avg_t;
    typedef logic [2:0]  apfc_ratio_t;
    typedef logic [10:0] apfc_count_t;
endpackage : apfc_pkg

// File: common/apfc_cfg_if.sv
// Purpose: Carries the stored configuration word from register file to decoder
// Assumes: Single clock domain
// Notes:   src drives, dst reads
`timescale 1ns/10ps
`default_nettype none
interface apfc_cfg_if;
    import apfc_pkg::*;
    apfc_word_t cfg;
    modport src (output cfg);
    modport dst (input cfg);
endinterface : apfc_cfg_if
`default_nettype wire

// File: core/apfc_decode.sv
// Purpose: Turns the configuration word into registered filter controls
// Assumes: cfg word already masked and reset to its documented value
// Notes:   One cycle from word to controls
`timescale 1ns/10ps
`default_nettype none
`include "apfc_regs.svh"
module apfc_decode
    import apfc_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    apfc_cfg_if.dst     cfg_bus,
    output logic        dft_clock_gate,
    output logic        wavegen_clock_gate,
    output logic        mains_filter_clock_gate,
    output logic        average_enable,
    output apfc_avg_t   average_samples,
    output logic        dft_source_average,
    output apfc_ratio_t first_stage_ratio,
    output logic        first_stage_bypass,
    output apfc_count_t second_stage_count,
    output logic [4:0]  low_control
);
    logic        next_dft_gate;
    logic        next_wave_gate;
    logic        next_mains_gate;
    logic        next_avg_en;
    apfc_avg_t   next_avg;
    logic        next_src;
    apfc_ratio_t next_ratio;
    logic        next_byp;
    apfc_count_t next_count;
    logic [4:0]  next_low;
    apfc_word_t  w;

    always_comb begin
        w               = cfg_bus.cfg;
        next_dft_gate   = w[`APFC_DFT_GATE_BIT];   // see (R1)
        next_wave_gate  = w[`APFC_WAVE_GATE_BIT];  // see (R1)
        next_mains_gate = w[`APFC_MAINS_GATE_BIT]; // see (R1)
        next_avg_en     = w[`APFC_AVG_EN_BIT];     // see (R10)
        next_byp        = w[`APFC_S3_BYP_BIT];     // see (R11)
        next_low        = w[`APFC_LOW_HI:`APFC_LOW_LO];
        next_src        = next_avg_en;             // see (R3)
        // Count only applies while averaging is on
        next_avg = 5'h00;                          // see (R4)
        if (next_avg_en) begin
            case (w[`APFC_AVG_CNT_HI:`APFC_AVG_CNT_LO]) // see (R2)
                2'h0:    next_avg = 5'h02;
                2'h1:    next_avg = 5'h04;
                2'h2:    next_avg = 5'h08;
                default: next_avg = 5'h10;
            endcase
        end
        case (w[`APFC_S3_DEC_HI:`APFC_S3_DEC_LO]) // see (R5)
            2'h1:    next_ratio = 3'h4;
            2'h2:    next_ratio = 3'h2;
            default: next_ratio = 3'h5;
        endcase
        case (w[`APFC_S2_DEC_HI:`APFC_S2_DEC_LO])
            4'h0:    next_count = 11'h016;  // see (R7)
            4'h1:    next_count = 11'h02C;  // see (R9)
            4'h2:    next_count = 11'h059;
            4'h3:    next_count = 11'h0B2;
            4'h4:    next_count = 11'h10B;
            4'h5:    next_count = 11'h215;
            4'h6:    next_count = 11'h280;
            4'h7:    next_count = 11'h29B;
            4'h8:    next_count = 11'h320;
            4'h9:    next_count = 11'h379;
            4'hA:    next_count = 11'h42B;
            4'hB:    next_count = 11'h535;
            default: next_count = 11'h016;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dft_clock_gate          <= 1'b0;
            wavegen_clock_gate      <= 1'b0;
            mains_filter_clock_gate <= 1'b0;
            average_enable          <= 1'b0;
            average_samples         <= 5'h00;
            dft_source_average      <= 1'b0;
            first_stage_ratio       <= 3'h5;
            first_stage_bypass      <= 1'b0;
            second_stage_count      <= 11'h0B2;
            low_control             <= 5'h01;
        end else begin
            dft_clock_gate          <= next_dft_gate;
            wavegen_clock_gate      <= next_wave_gate;
            mains_filter_clock_gate <= next_mains_gate;
            average_enable          <= next_avg_en;
            average_samples         <= next_avg;
            dft_source_average      <= next_src;
            first_stage_ratio       <= next_ratio;
            first_stage_bypass      <= next_byp;
            second_stage_count      <= next_count;
            low_control             <= next_low;
        end
    end
endmodule : apfc_decode
`default_nettype wire

// File: core/apfc_top.sv
// Purpose: ADC post-filter configuration register with AXI4-Lite access
// Assumes: CORE_CLK 100 MHz, single clock, RST_N asynchronous active low
// Notes:   Behaviour
// Behaviour
// (R1) Bits 18,17,16 stop DFT, wavegen, mains clocks
// (R2) Average count codes select 2,4,8,16 samples
// (R3) Averaging on routes averager into DFT
// (R4) Count applies only with average enable set
// (R5) First-stage codes give ratios 5,4,2,5
// (R6) Software picks ratio matching ADC sample rate
// (R7) Second-stage field resets 3; code 0 gives 22
// (R8) Register at 0x2044, resets to 0x301
// (R9) Codes 1..11 give 44 through 1333
// (R10) Bit 7 enables averaging
// (R11) Bit 6 bypasses first-stage filter
// (R12) Bits 31:19 read zero, ignore writes
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "apfc_regs.svh"
module apfc_top
    import apfc_pkg::*;
(
    input  wire logic                     CORE_CLK,
    input  wire logic                     RST_N,
    input  wire logic [`APFC_ADDR_W-1:0]  S_AXI_AWADDR,
    input  wire logic                     S_AXI_AWVALID,
    output logic                          S_AXI_AWREADY,
    input  wire apfc_word_t               S_AXI_WDATA,
    input  wire apfc_strb_t               S_AXI_WSTRB,
    input  wire logic                     S_AXI_WVALID,
    output logic                          S_AXI_WREADY,
    output apfc_resp_t                    S_AXI_BRESP,
    output logic                          S_AXI_BVALID,
    input  wire logic                     S_AXI_BREADY,
    input  wire logic [`APFC_ADDR_W-1:0]  S_AXI_ARADDR,
    input  wire logic                     S_AXI_ARVALID,
    output logic                          S_AXI_ARREADY,
    output apfc_word_t                    S_AXI_RDATA,
    output apfc_resp_t                    S_AXI_RRESP,
    output logic                          S_AXI_RVALID,
    input  wire logic                     S_AXI_RREADY,
    output logic                          DFT_CLOCK_GATE,
    output logic                          WAVEGEN_CLOCK_GATE,
    output logic                          MAINS_FILTER_CLOCK_GATE,
    output logic                          AVERAGE_ENABLE,
    output apfc_avg_t                     AVERAGE_SAMPLES,
    output logic                          DFT_SOURCE_AVERAGE,
    output apfc_ratio_t                   FIRST_STAGE_RATIO,
    output logic                          FIRST_STAGE_BYPASS,
    output apfc_count_t                   SECOND_STAGE_COUNT,
    output logic [4:0]                    LOW_CONTROL
);
    logic                    rst_meta;
    logic                    rst_n_sync;
    apfc_word_t              cfg;
    apfc_word_t              next_cfg;
    logic                    aw_held;
    logic                    next_aw_held;
    logic [`APFC_ADDR_W-1:0] aw_addr;
    logic [`APFC_ADDR_W-1:0] next_aw_addr;
    logic                    w_held;
    logic                    next_w_held;
    apfc_word_t              w_data;
    apfc_word_t              next_w_data;
    apfc_strb_t              w_strb;
    apfc_strb_t              next_w_strb;
    logic                    next_awready;
    logic                    next_wready;
    logic                    next_bvalid;
    apfc_resp_t              next_bresp;
    logic                    next_arready;
    logic                    next_rvalid;
    apfc_word_t              next_rdata;
    apfc_resp_t              next_rresp;
    apfc_word_t              merged;
    apfc_word_t              status;

    apfc_cfg_if cfg_bus ();
    assign cfg_bus.cfg = cfg;

    // Reset asserts at once, releases after two edges
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta   <= 1'b0;
            rst_n_sync <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_n_sync <= rst_meta;
        end
    end

    // Byte-lane merge of held write data into the stored word
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign merged[gi*8 +: 8] = w_strb[gi] ? w_data[gi*8 +: 8] : cfg[gi*8 +: 8];
        end
    endgenerate

    assign status = {12'h000,
                     DFT_SOURCE_AVERAGE,
                     SECOND_STAGE_COUNT,
                     FIRST_STAGE_RATIO,
                     AVERAGE_SAMPLES};

    // Address and data may be taken in either order
    always_comb begin
        next_cfg     = cfg;
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held  = w_held;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = S_AXI_BVALID;
        next_bresp   = S_AXI_BRESP;
        if (S_AXI_BVALID && S_AXI_BREADY) begin
            next_bvalid = 1'b0;
        end
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            next_aw_held = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            next_w_held = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
        end
        // Both halves held: commit once and answer
        if (aw_held && w_held && !S_AXI_BVALID) begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            if ({aw_addr[`APFC_ADDR_W-1:2], 2'b00} == `APFC_CFG_ADDR) begin // see (R8)
                next_cfg   = merged & `APFC_CFG_WMASK; // see (R12)
                next_bresp = `APFC_RESP_OKAY;
            end else begin
                next_bresp = `APFC_RESP_SLVERR;
            end
        end
        // No new halves until the response is taken
        next_awready = !next_aw_held && !next_bvalid;
        next_wready  = !next_w_held && !next_bvalid;
    end

    always_ff @(posedge CORE_CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            cfg           <= `APFC_CFG_RESET; // see (R8)
            aw_held       <= 1'b0;
            aw_addr       <= '0;
            w_held        <= 1'b0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `APFC_RESP_OKAY;
        end else begin
            cfg           <= next_cfg;
            aw_held       <= next_aw_held;
            aw_addr       <= next_aw_addr;
            w_held        <= next_w_held;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            S_AXI_AWREADY <= next_awready;
            S_AXI_WREADY  <= next_wready;
            S_AXI_BVALID  <= next_bvalid;
            S_AXI_BRESP   <= next_bresp;
        end
    end

    // Read answers on the same edge that takes the address
    always_comb begin
        next_rvalid = S_AXI_RVALID;
        next_rdata  = S_AXI_RDATA;
        next_rresp  = S_AXI_RRESP;
        if (S_AXI_RVALID && S_AXI_RREADY) begin
            next_rvalid = 1'b0;
        end
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            next_rvalid = 1'b1;
            next_rresp  = `APFC_RESP_OKAY;
            // Low two address bits are ignored
            case ({S_AXI_ARADDR[`APFC_ADDR_W-1:2], 2'b00})
                `APFC_CFG_ADDR:  next_rdata = cfg; // see (R12)
                `APFC_STAT_ADDR: next_rdata = status;
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = `APFC_RESP_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge CORE_CLK or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= `APFC_RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= next_arready;
            S_AXI_RVALID  <= next_rvalid;
            S_AXI_RDATA   <= next_rdata;
            S_AXI_RRESP   <= next_rresp;
        end
    end

    // Controls to the filter chain, registered in the decoder
    apfc_decode u_decode (
        .clk                     (CORE_CLK),
        .rst_n                   (rst_n_sync),
        .cfg_bus                 (cfg_bus.dst),
        .dft_clock_gate          (DFT_CLOCK_GATE),
        .wavegen_clock_gate      (WAVEGEN_CLOCK_GATE),
        .mains_filter_clock_gate (MAINS_FILTER_CLOCK_GATE),
        .average_enable          (AVERAGE_ENABLE),
        .average_samples         (AVERAGE_SAMPLES),
        .dft_source_average      (DFT_SOURCE_AVERAGE),
        .first_stage_ratio       (FIRST_STAGE_RATIO),
        .first_stage_bypass      (FIRST_STAGE_BYPASS),
        .second_stage_count      (SECOND_STAGE_COUNT),
        .low_control             (LOW_CONTROL)
    );
endmodule : apfc_top
`default_nettype wire

// File: tb/apfc_top_sva.sv
// Purpose: Port-level assertions for the post-filter configuration block
// Assumes: One clock; bound from the testbench top
// Notes:   Controls settle three edges after a full-word write
`timescale 1ns/10ps
`default_nettype none
`include "apfc_regs.svh"
module apfc_sva
    import apfc_pkg::*;
(
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic [15:0] S_AXI_AWADDR,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire apfc_word_t  S_AXI_WDATA,
    input wire apfc_strb_t  S_AXI_WSTRB,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire apfc_resp_t  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire apfc_word_t  S_AXI_RDATA,
    input wire logic        S_AXI_RVALID,
    input wire logic        DFT_CLOCK_GATE,
    input wire logic        WAVEGEN_CLOCK_GATE,
    input wire logic        MAINS_FILTER_CLOCK_GATE,
    input wire logic        AVERAGE_ENABLE,
    input wire apfc_avg_t   AVERAGE_SAMPLES,
    input wire logic        DFT_SOURCE_AVERAGE,
    input wire apfc_ratio_t FIRST_STAGE_RATIO,
    input wire logic        FIRST_STAGE_BYPASS,
    input wire apfc_count_t SECOND_STAGE_COUNT,
    input wire logic [4:0]  LOW_CONTROL
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    sequence s_wr_hs;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    endsequence
    sequence s_cfg_wr;
        s_wr_hs ##0 ({S_AXI_AWADDR[15:2], 2'b00} == `APFC_CFG_ADDR && S_AXI_WSTRB == 4'hF);
    endsequence
    property p_bits;
        apfc_word_t d;
        (s_cfg_wr, d = S_AXI_WDATA) |-> ##3 {DFT_CLOCK_GATE, WAVEGEN_CLOCK_GATE,
            MAINS_FILTER_CLOCK_GATE, AVERAGE_ENABLE, FIRST_STAGE_BYPASS} == {d[18:16], d[7:6]};
    endproperty
    property p_avg;
        apfc_word_t d;
        (s_cfg_wr, d = S_AXI_WDATA) |-> ##3
            AVERAGE_SAMPLES == (d[7] ? 5'h02 << d[15:14] : 5'h00);
    endproperty
    property p_ratio;
        apfc_word_t d;
        (s_cfg_wr, d = S_AXI_WDATA) |-> ##3 FIRST_STAGE_RATIO ==
            ((d[13:12] == 2'h1) ? 3'h4 : (d[13:12] == 2'h2) ? 3'h2 : 3'h5);
    endproperty
    property p_s2;
        apfc_word_t d;
        (s_cfg_wr, d = S_AXI_WDATA) |-> ##3 (d[11:8] != 4'h0 || SECOND_STAGE_COUNT == 11'h016);
    endproperty
    property p_off;
        !AVERAGE_ENABLE |-> AVERAGE_SAMPLES == 5'h00;
    endproperty
    property p_src;
        DFT_SOURCE_AVERAGE == (AVERAGE_SAMPLES != 5'h00);
    endproperty
    property p_reset;
        $rose(RST_N) |-> FIRST_STAGE_RATIO == 3'h5 && SECOND_STAGE_COUNT == 11'h0B2
            && LOW_CONTROL == 5'h01 && !AVERAGE_ENABLE && !DFT_CLOCK_GATE;
    endproperty
    property p_slverr;
        s_wr_hs ##0 ({S_AXI_AWADDR[15:2], 2'b00} != `APFC_CFG_ADDR) |->
            ##[1:3] (S_AXI_BVALID && S_AXI_BRESP == `APFC_RESP_SLVERR);
    endproperty
    property p_rsvd;
        S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && S_AXI_RDATA[31:20] == 12'h000;
    endproperty
    a_bits: assert property (p_bits) else $error("control bits wrong");
    a_avg: assert property (p_avg) else $error("average samples wrong");
    a_ratio: assert property (p_ratio) else $error("first stage ratio wrong");
    a_s2: assert property (p_s2) else $error("second stage code zero wrong");
    a_off: assert property (p_off) else $error("count applied while off");
    a_src: assert property (p_src) else $error("DFT source wrong");
    a_reset: assert property (p_reset) else $error("reset decode wrong");
    a_slverr: assert property (p_slverr) else $error("unmapped write not refused");
    a_rsvd: assert property (p_rsvd) else $error("reserved read bits set");
endmodule : apfc_sva
`default_nettype wire

// File: tb/apfc_top_tb.sv
// Purpose: Self-checking bench of the post-filter configuration block
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes:   Random words from a fixed seed plus every averaging, ratio and count code
`timescale 1ns/10ps
`default_nettype none
`include "apfc_regs.svh"
module adc_postfilter_config_tb
    import apfc_pkg::*;
;
    logic        CORE_CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
    logic        S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY;
    logic        S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, DFT_CLOCK_GATE;
    logic        WAVEGEN_CLOCK_GATE, MAINS_FILTER_CLOCK_GATE, AVERAGE_ENABLE;
    logic        DFT_SOURCE_AVERAGE, FIRST_STAGE_BYPASS;
    logic [15:0] S_AXI_AWADDR, S_AXI_ARADDR;
    logic [4:0]  LOW_CONTROL;
    apfc_word_t  S_AXI_WDATA, S_AXI_RDATA, model, d;
    apfc_strb_t  S_AXI_WSTRB;
    apfc_resp_t  S_AXI_BRESP, S_AXI_RRESP;
    apfc_avg_t   AVERAGE_SAMPLES;
    apfc_ratio_t FIRST_STAGE_RATIO;
    apfc_count_t SECOND_STAGE_COUNT;
    int          num_errors = 0;
    int          checked = 0;
    int          seed = 80731;
    apfc_count_t cnt_tab [16] = '{11'h016, 11'h02C, 11'h059, 11'h0B2, 11'h10B, 11'h215,
        11'h280, 11'h29B, 11'h320, 11'h379, 11'h42B, 11'h535, 11'h016, 11'h016, 11'h016, 11'h016};

    apfc_top dut_u (.*);

    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Status word layout, also the decode of the averaging, DFT source, ratio and count outputs
    function automatic apfc_word_t status_of(input apfc_word_t w);
        apfc_avg_t   a;
        apfc_ratio_t r;
        a = w[7] ? 5'h02 << w[15:14] : 5'h00;
        r = (w[13:12] == 2'h1) ? 3'h4 : (w[13:12] == 2'h2) ? 3'h2 : 3'h5;
        return {12'h000, w[7], cnt_tab[w[11:8]], r, a};
    endfunction : status_of

    task automatic check_outputs;
        apfc_word_t e;
        e = status_of(model);
        check("gates", {DFT_CLOCK_GATE, WAVEGEN_CLOCK_GATE, MAINS_FILTER_CLOCK_GATE},
              model[18:16]);
        check("average",
              {AVERAGE_ENABLE, DFT_SOURCE_AVERAGE, AVERAGE_SAMPLES}, {model[7], e[19], e[4:0]});
        check("first stage", {FIRST_STAGE_BYPASS, FIRST_STAGE_RATIO},
              {model[6], e[7:5]});
        check("second stage", SECOND_STAGE_COUNT, e[18:8]);
        check("low bits", LOW_CONTROL, model[4:0]);
    endtask : check_outputs

    task automatic axi_wr(input logic [15:0] a, input apfc_word_t w, input apfc_strb_t st,
                          input apfc_resp_t er);
        bit done;
        @(posedge CORE_CLK);
        done = 0;
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= w;
        S_AXI_WSTRB <= st;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge CORE_CLK);
            if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
            if (S_AXI_BVALID === 1'b1) begin
                S_AXI_BREADY <= 1'b0;
                check("write response", S_AXI_BRESP, er);
                done = 1;
            end
        end
        if (!done) begin
            num_errors++;
            finish_test();
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [15:0] a, input apfc_word_t ed, input apfc_resp_t er);
        bit done;
        @(posedge CORE_CLK);
        done = 0;
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            @(posedge CORE_CLK);
            if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
            if (S_AXI_RVALID === 1'b1) begin
                S_AXI_RREADY <= 1'b0;
                check("read data", S_AXI_RDATA, ed);
                check("read response", S_AXI_RRESP, er);
                done = 1;
            end
        end
        if (!done) begin
            num_errors++;
            finish_test();
        end
    endtask : axi_rd

    task automatic cfg_wr(input apfc_word_t w, input apfc_strb_t st);
        apfc_word_t m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        model = ((model & ~m) | (w & m)) & `APFC_CFG_WMASK;
        axi_wr(`APFC_CFG_ADDR, w, st, `APFC_RESP_OKAY);
        @(posedge CORE_CLK);
        #1;
        check_outputs();
        axi_rd(`APFC_CFG_ADDR, model, `APFC_RESP_OKAY);
        axi_rd(`APFC_STAT_ADDR, status_of(model), `APFC_RESP_OKAY);
    endtask : cfg_wr

    task automatic do_reset(input int cycles);
        @(posedge CORE_CLK);
        RST_N <= 1'b0;
        repeat (cycles) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        model = `APFC_CFG_RESET;
        repeat (3) @(posedge CORE_CLK);
        #1;
        check_outputs();
        axi_rd(`APFC_CFG_ADDR, model, `APFC_RESP_OKAY);
    endtask : do_reset

    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    initial begin
        RST_N = 1'b0;
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
        S_AXI_AWADDR = 16'h0000;
        S_AXI_ARADDR = 16'h0000;
        S_AXI_WDATA = 32'h00000000;
        S_AXI_WSTRB = 4'h0;
        do_reset(16);
        cfg_wr(32'hFFFFFFFF, 4'hF);
        cfg_wr(32'h00000000, 4'hF);
        for (int i = 0; i < 32; i++) begin
            d = $random(seed);
            d[11:8] = i[3:0];
            d[13:12] = i[1:0];
            d[15:14] = i[3:2];
            d[7] = ~i[0];
            cfg_wr(d, (i < 16) ? 4'hF : 4'($random(seed)));
        end
        // Refused accesses leave the stored word alone
        axi_wr(16'h2050, $random(seed), 4'hF, `APFC_RESP_SLVERR);
        axi_wr(`APFC_STAT_ADDR, $random(seed), 4'hF, `APFC_RESP_SLVERR);
        axi_rd(16'h2050, 32'h00000000, `APFC_RESP_SLVERR);
        axi_rd(`APFC_CFG_ADDR, model, `APFC_RESP_OKAY);
        do_reset(4);
        finish_test();
    end
endmodule : adc_postfilter_config_tb

bind apfc_top apfc_sva chk_u (.*);
`default_nettype wire
